// ==== rtl/tps_defines.svh ====
// Timing and reset constants for the TMS path sequencer.
// Assumes it is included by the package and the sequencer; guarded.
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// Longest TMS path in TCK cycles, and width of its down-counter
`define TPS_PAT_W 7
`define TPS_LEN_W 3

// TMS level that holds Test-Logic-Reset, and level for other stable states
`define TPS_TMS_HOLD_TLR 1'h1
`define TPS_TMS_HOLD_OTHER 1'h0

// TMS level driven out of reset
`define TPS_TMS_RESET 1'h1

`endif

// ==== rtl/tps_pkg.sv ====
// Types and path tables for the TMS path sequencer.
// Assumes tps_defines.svh is reachable on the include path.
`include "tps_defines.svh"

package tps_pkg;

  // TAP controller states; the order gives the four-bit status code
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tps_tap_t;

  // Sequencer phases
  typedef enum logic [1:0] {PH_IDLE, PH_ARM, PH_RUN} tps_phase_t;

  // One TMS path: bits sent LSB first, len zero means no such path
  typedef struct packed {
    logic [`TPS_PAT_W-1:0] pat;
    logic [`TPS_LEN_W-1:0] len;
  } tps_seq_t;

  // Target TAP controller state after one TCK rising edge
  function automatic tps_tap_t tps_next(input tps_tap_t s, input logic tms);
    tps_tap_t n;
    n = s;
    unique case (s)
      TLR: n = tms ? TLR : RTI;
      RTI: n = tms ? SEL_DR : RTI;
      SEL_DR: n = tms ? SEL_IR : CAP_DR;
      CAP_DR: n = tms ? EX1_DR : SHF_DR;
      SHF_DR: n = tms ? EX1_DR : SHF_DR;
      EX1_DR: n = tms ? UPD_DR : PAU_DR;
      PAU_DR: n = tms ? EX2_DR : PAU_DR;
      EX2_DR: n = tms ? UPD_DR : SHF_DR;
      UPD_DR: n = tms ? SEL_DR : RTI;
      SEL_IR: n = tms ? TLR : CAP_IR;
      CAP_IR: n = tms ? EX1_IR : SHF_IR;
      SHF_IR: n = tms ? EX1_IR : SHF_IR;
      EX1_IR: n = tms ? UPD_IR : PAU_IR;
      PAU_IR: n = tms ? EX2_IR : PAU_IR;
      EX2_IR: n = tms ? UPD_IR : SHF_IR;
      UPD_IR: n = tms ? SEL_DR : RTI;
    endcase
    return n;
  endfunction : tps_next

  // Path table from each supported start state to up to six target states
  function automatic tps_seq_t tps_path(input tps_tap_t s, input tps_tap_t t);
    tps_seq_t q;
    q = '0;
    unique case (s)
      TLR: begin
        unique case (t)
          TLR: q = '{7'h01, 3'h1};
          RTI: q = '{7'h00, 3'h1};
          SHF_DR: q = '{7'h02, 3'h4};
          PAU_DR: q = '{7'h0A, 3'h5};
          SHF_IR: q = '{7'h06, 3'h5};
          PAU_IR: q = '{7'h16, 3'h6};
          default: q = '0;
        endcase
      end
      RTI: begin
        unique case (t)
          TLR: q = '{7'h07, 3'h3};
          RTI: q = '{7'h00, 3'h1};
          SHF_DR: q = '{7'h01, 3'h3};
          PAU_DR: q = '{7'h05, 3'h4};
          SHF_IR: q = '{7'h03, 3'h4};
          PAU_IR: q = '{7'h0B, 3'h5};
          default: q = '0;
        endcase
      end
      PAU_DR: begin
        unique case (t)
          TLR: q = '{7'h1F, 3'h5};
          RTI: q = '{7'h03, 3'h3};
          SHF_DR: q = '{7'h01, 3'h2};
          PAU_DR: q = '{7'h17, 3'h6};
          SHF_IR: q = '{7'h0F, 3'h6};
          PAU_IR: q = '{7'h2F, 3'h7};
          default: q = '0;
        endcase
      end
      PAU_IR: begin
        unique case (t)
          TLR: q = '{7'h1F, 3'h5};
          RTI: q = '{7'h03, 3'h3};
          SHF_DR: q = '{7'h07, 3'h5};
          PAU_DR: q = '{7'h17, 3'h6};
          SHF_IR: q = '{7'h01, 3'h2};
          PAU_IR: q = '{7'h2F, 3'h7};
          default: q = '0;
        endcase
      end
      SHF_DR: begin
        unique case (t)
          TLR: q = '{7'h1F, 3'h5};
          RTI: q = '{7'h03, 3'h3};
          PAU_DR: q = '{7'h01, 3'h2};
          PAU_IR: q = '{7'h2F, 3'h7};
          default: q = '0;
        endcase
      end
      default: q = '0;
    endcase
    return q;
  endfunction : tps_path

endpackage : tps_pkg

// ==== rtl/tps_sequencer.sv ====
// TMS path sequencer: walks target TAP controllers between states.
// Assumes TCK comes from outside this clock domain and is much slower
// than REF_CLK_IN; GO_IN and TARGET_IN come from logic on REF_CLK_IN.
`timescale 1ns/10ps
`include "tps_defines.svh"

// What this block does
// - From Run-Test/Idle: reset via HHH, Pause-DR via HLHL.
// - From idle: hold L, Shift-DR HLL, Shift-IR HHLL, Pause-IR HHLHL.
// - From Pause-DR: reset via five highs, Run-Test/Idle via HHL.
// - Pause-DR: Shift-DR HL, self HHHLHL, Shift-IR HHHHLL, Pause-IR HHHHLHL.
// - From Pause-IR: reset via five highs, Run-Test/Idle HHL, Shift-IR HL.
// - From Pause-IR: Shift-DR HHHLL, Pause-DR HHHLHL, Pause-IR HHHHLHL.
// - From Shift-DR: Pause-DR HL, idle HHL, reset HHHHH, Pause-IR HHHHLHL.
// - Current tracked TAP state is shown continuously as a four-bit field.
// - Any reset puts the tracked state in Test-Logic-Reset.
module tps_sequencer (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // TCK as seen on the link
  input wire logic TCK_IN,
  // Path request
  input wire logic GO_IN,
  input wire tps_pkg::tps_tap_t TARGET_IN,
  // Link and status
  output logic TMS_OUT,
  output logic [3:0] TAP_STATE_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic sync3_q, sync3_d;
  logic tck_q, tck_d;
  logic rise, fall, accept;
  tps_pkg::tps_phase_t phase_q, phase_d;
  tps_pkg::tps_tap_t tap_q, tap_d, tgt_q, tgt_d, step;
  tps_pkg::tps_seq_t sel;
  logic [`TPS_PAT_W-1:0] pat_q, pat_d;
  logic [`TPS_LEN_W-1:0] cnt_q, cnt_d;
  logic tms_q, tms_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // TCK edge finding: a level change counts once stages two and three agree
  always_comb begin
    sync1_d = TCK_IN;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    tck_d = (sync2_q == sync3_q) ? sync3_q : tck_q;
    rise = tck_d & ~tck_q;
    fall = ~tck_d & tck_q;
  end

  // Path lookup; starts with no table leave len at zero and are refused
  always_comb begin
    sel = tps_pkg::tps_path(tap_q, TARGET_IN);
    accept = (phase_q == tps_pkg::PH_IDLE) && GO_IN && (sel.len != '0);
    step = tps_pkg::tps_next(tap_q, tms_q);
  end

  // Sequencer next state
  always_comb begin
    phase_d = phase_q;
    tap_d = tap_q;
    tgt_d = tgt_q;
    pat_d = pat_q;
    cnt_d = cnt_q;
    tms_d = tms_q;
    busy_d = busy_q;
    done_d = 1'h0;
    unique case (phase_q)
      tps_pkg::PH_IDLE: begin
        if (accept) begin
          pat_d = sel.pat;
          cnt_d = sel.len;
          tgt_d = TARGET_IN;
          busy_d = 1'h1;
          phase_d = tps_pkg::PH_ARM;
        end
      end
      // First bit waits for a falling edge so it cannot race a rise
      tps_pkg::PH_ARM: begin
        if (fall) begin
          tms_d = pat_q[0];
          phase_d = tps_pkg::PH_RUN;
        end
      end
      tps_pkg::PH_RUN: begin
        if (rise) begin
          tap_d = step;
          pat_d = pat_q >> 1;
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            phase_d = tps_pkg::PH_IDLE;
            busy_d = 1'h0;
            done_d = 1'h1;
            tms_d = (step == tps_pkg::TLR) ? `TPS_TMS_HOLD_TLR
                                           : `TPS_TMS_HOLD_OTHER;
          end else begin
            tms_d = pat_q[1];
          end
        end
      end
    endcase
  end

  // All state registers
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
      sync3_q <= 1'h0;
      tck_q <= 1'h0;
      phase_q <= tps_pkg::PH_IDLE;
      tap_q <= tps_pkg::TLR;
      tgt_q <= tps_pkg::TLR;
      pat_q <= '0;
      cnt_q <= '0;
      tms_q <= `TPS_TMS_RESET;
      busy_q <= 1'h0;
      done_q <= 1'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      tck_q <= tck_d;
      phase_q <= phase_d;
      tap_q <= tap_d;
      tgt_q <= tgt_d;
      pat_q <= pat_d;
      cnt_q <= cnt_d;
      tms_q <= tms_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flip-flops
  assign TMS_OUT = tms_q;
  assign TAP_STATE_OUT = tap_q;
  assign BUSY_OUT = busy_q;
  assign DONE_OUT = done_q;

  // Checks on the sequencer
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  rti_paths_a: assert property (accept && tap_q == tps_pkg::RTI &&
      TARGET_IN == tps_pkg::PAU_DR |=> cnt_q == 3'h4 && pat_q == 7'h05)
    else $error("wrong path from idle to Pause-DR");
  rti_shift_a: assert property (accept && tap_q == tps_pkg::RTI &&
      TARGET_IN == tps_pkg::SHF_IR |=> cnt_q == 3'h4 && pat_q == 7'h03)
    else $error("wrong path from idle to Shift-IR");
  pdr_idle_a: assert property (accept && tap_q == tps_pkg::PAU_DR &&
      TARGET_IN == tps_pkg::RTI |=> cnt_q == 3'h3 && pat_q == 7'h03)
    else $error("wrong path from Pause-DR to idle");
  pdr_pir_a: assert property (accept && tap_q == tps_pkg::PAU_DR &&
      TARGET_IN == tps_pkg::PAU_IR |=> cnt_q == 3'h7 && pat_q == 7'h2F)
    else $error("wrong path from Pause-DR to Pause-IR");
  pir_shift_a: assert property (accept && tap_q == tps_pkg::PAU_IR &&
      TARGET_IN == tps_pkg::SHF_IR |=> cnt_q == 3'h2 && pat_q == 7'h01)
    else $error("wrong path from Pause-IR to Shift-IR");
  pir_sdr_a: assert property (accept && tap_q == tps_pkg::PAU_IR &&
      TARGET_IN == tps_pkg::SHF_DR |=> cnt_q == 3'h5 && pat_q == 7'h07)
    else $error("wrong path from Pause-IR to Shift-DR");
  sdr_reset_a: assert property (accept && tap_q == tps_pkg::SHF_DR &&
      TARGET_IN == tps_pkg::TLR |=> cnt_q == 3'h5 && pat_q == 7'h1F)
    else $error("wrong path from Shift-DR to reset");
  tms_hold_a: assert property ((phase_q == tps_pkg::PH_RUN) && !rise
      |=> $stable(tms_q))
    else $error("TMS moved away from a TCK rise");
  end_state_a: assert property ($rose(done_q) |->
      TAP_STATE_OUT == tgt_q && !busy_q)
    else $error("finished away from the requested state");
  tap_step_a: assert property (!rise |=> $stable(tap_q))
    else $error("TAP state moved without a TCK rise");
  tms_arm_a: assert property ((phase_q == tps_pkg::PH_ARM) && !fall
      |=> $stable(tms_q))
    else $error("TMS moved before the first TCK fall");
  busy_phase_a: assert property (
      busy_q == (phase_q != tps_pkg::PH_IDLE))
    else $error("busy flag out of step with the sequencer");
  reset_state_a: assert property ($rose(RESETN_IN) |->
      tap_q == tps_pkg::TLR && tms_q && !busy_q)
    else $error("left reset away from Test-Logic-Reset");

  // Seven more path table entries, one per rule
  rti_tlr_a: assert property (accept && tap_q == tps_pkg::RTI &&
      TARGET_IN == tps_pkg::TLR |=> cnt_q == 3'h3 && pat_q == 7'h07)
    else $error("wrong path from idle to reset");
  rti_hold_a: assert property (accept && tap_q == tps_pkg::RTI &&
      TARGET_IN == tps_pkg::RTI |=> cnt_q == 3'h1 && pat_q == 7'h00)
    else $error("wrong path from idle to idle");
  pdr_reset_a: assert property (accept && tap_q == tps_pkg::PAU_DR &&
      TARGET_IN == tps_pkg::TLR |=> cnt_q == 3'h5 && pat_q == 7'h1F)
    else $error("wrong path from Pause-DR to reset");
  pdr_sir_a: assert property (accept && tap_q == tps_pkg::PAU_DR &&
      TARGET_IN == tps_pkg::SHF_IR |=> cnt_q == 3'h6 && pat_q == 7'h0F)
    else $error("wrong path from Pause-DR to Shift-IR");
  pir_reset_a: assert property (accept && tap_q == tps_pkg::PAU_IR &&
      TARGET_IN == tps_pkg::TLR |=> cnt_q == 3'h5 && pat_q == 7'h1F)
    else $error("wrong path from Pause-IR to reset");
  pir_pir_a: assert property (accept && tap_q == tps_pkg::PAU_IR &&
      TARGET_IN == tps_pkg::PAU_IR |=> cnt_q == 3'h7 && pat_q == 7'h2F)
    else $error("wrong path from Pause-IR to Pause-IR");
  sdr_pdr_a: assert property (accept && tap_q == tps_pkg::SHF_DR &&
      TARGET_IN == tps_pkg::PAU_DR |=> cnt_q == 3'h2 && pat_q == 7'h01)
    else $error("wrong path from Shift-DR to Pause-DR");

  go_sdr_c: cover property (accept && TARGET_IN == tps_pkg::SHF_DR);
  pir_done_c: cover property (done_q && tap_q == tps_pkg::PAU_IR);
  refused_c: cover property (phase_q == tps_pkg::PH_IDLE && GO_IN
      && !accept);
  sdr_exit_c: cover property (accept && tap_q == tps_pkg::SHF_DR);
  tlr_done_c: cover property (done_q && tap_q == tps_pkg::TLR);

endmodule : tps_sequencer

// ==== verif/tps_tap_model.sv ====
// Target TAP controller model on the far side of TMS.
// Assumes the bench makes TCK and shares its reset with the sequencer.
`timescale 1ns/10ps
module tps_tap_model (
  // Link
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic resetn_in,
  // Observed controller state
  output logic [3:0] state_out
);
  // Next state for TMS high and low, one nibble per state code
  localparam logic [63:0] NX_HI = 64'h2FEFCC0287855920;
  localparam logic [63:0] NX_LO = 64'h1BDDBBA146644311;

  // Advances on the TCK rise only, so early TMS changes do no harm
  always_ff @(posedge tck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_out <= 4'h0;
    end else if (tms_in) begin
      state_out <= NX_HI[{state_out, 2'h0} +: 4];
    end else begin
      state_out <= NX_LO[{state_out, 2'h0} +: 4];
    end
  end
endmodule : tps_tap_model

// ==== verif/tb_tps_sequencer.sv ====
// Bench for the TMS path sequencer driving one target TAP model.
// Assumes the package, the sequencer and the model compile first.
`timescale 1ns/10ps
module tb_tps_sequencer;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic tck = 1'h0;
  logic go = 1'h0;
  tps_pkg::tps_tap_t target = tps_pkg::TLR;
  logic tms, busy, done;
  logic [3:0] tap_state, model_state;
  logic [7:0] bits;
  int nbits, miscompares, num_checks, cycles;

  // Reference clock, and a free TCK out of phase with it
  always #50 ref_clk = ~ref_clk;
  initial #37 forever #400 tck = ~tck;

  tps_sequencer dut (
    .REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .TCK_IN(tck),
    .GO_IN(go), .TARGET_IN(target), .TMS_OUT(tms),
    .TAP_STATE_OUT(tap_state), .BUSY_OUT(busy), .DONE_OUT(done)
  );
  tps_tap_model target_tap (
    .tck_in(tck), .tms_in(tms), .resetn_in(resetn),
    .state_out(model_state)
  );

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Cut a hang short; paths take well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // At each TCK rise the shown state must be what the target holds
  always @(posedge tck) begin
    if (resetn) begin
      chk("tap_state", {4'h0, tap_state}, {4'h0, model_state});
      if (busy) begin
        bits[nbits] = tms;
        nbits++;
      end
    end
  end

  task automatic do_reset();
    resetn <= 1'h0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    chk("reset tms", {7'h0, tms}, 8'h01);
    chk("reset state", {4'h0, tap_state}, 8'h00);
    chk("reset busy", {7'h0, busy}, 8'h00);
    repeat (4) @(posedge ref_clk);
  endtask : do_reset

  // One path; a second request at cycle poke must be ignored
  task automatic leg(input tps_pkg::tps_tap_t t, input logic [7:0] pat,
                     input int len, input int poke = 0);
    int n;
    n = 0;
    @(posedge tck);
    @(posedge ref_clk);
    bits = 8'h00;
    nbits = 0;
    go <= 1'h1;
    target <= t;
    @(posedge ref_clk);
    go <= 1'h0;
    while (done !== 1'h1 && n < 200) begin
      @(posedge ref_clk);
      n++;
      go <= (n == poke);
      if (n == poke) begin
        target <= tps_pkg::TLR;
      end
    end
    chk("done", {7'h0, done}, 8'h01);
    chk("busy", {7'h0, busy}, 8'h00);
    chk("count", nbits[7:0], len[7:0]);
    chk("tms bits", bits, pat);
    chk("end state", {4'h0, tap_state}, {4'h0, t});
  endtask : leg

  task automatic t_idle();
    leg(tps_pkg::TLR, 8'h01, 1);
    leg(tps_pkg::RTI, 8'h00, 1);
    leg(tps_pkg::TLR, 8'h07, 3);
    leg(tps_pkg::RTI, 8'h00, 1);
    leg(tps_pkg::RTI, 8'h00, 1);
    leg(tps_pkg::PAU_DR, 8'h05, 4);
  endtask : t_idle

  task automatic t_pause_dr();
    leg(tps_pkg::SHF_DR, 8'h01, 2);
    leg(tps_pkg::PAU_IR, 8'h2F, 7, 10);
    leg(tps_pkg::SHF_DR, 8'h07, 5);
    leg(tps_pkg::PAU_DR, 8'h01, 2);
    leg(tps_pkg::PAU_DR, 8'h17, 6);
    leg(tps_pkg::PAU_IR, 8'h2F, 7);
  endtask : t_pause_dr

  // A request with no path must leave busy, TMS and the shown state alone
  task automatic refuse(input tps_pkg::tps_tap_t t, input logic [7:0] st);
    @(posedge ref_clk);
    go <= 1'h1;
    target <= t;
    @(posedge ref_clk);
    go <= 1'h0;
    repeat (30) @(posedge ref_clk);
    chk("refused busy", {7'h0, busy}, 8'h00);
    chk("refused tms", {7'h0, tms}, 8'h00);
    chk("refused state", {4'h0, tap_state}, st);
  endtask : refuse

  // Undefined pair first: no path, no change to busy, TMS or state
  task automatic t_pause_ir();
    refuse(tps_pkg::SEL_DR, 8'h0D);
    leg(tps_pkg::PAU_DR, 8'h17, 6);
    leg(tps_pkg::RTI, 8'h03, 3);
    leg(tps_pkg::PAU_IR, 8'h0B, 5);
    leg(tps_pkg::RTI, 8'h03, 3);
    leg(tps_pkg::PAU_IR, 8'h0B, 5);
    leg(tps_pkg::TLR, 8'h1F, 5);
  endtask : t_pause_ir

  task automatic t_shift();
    leg(tps_pkg::SHF_DR, 8'h02, 4);
    leg(tps_pkg::TLR, 8'h1F, 5);
    leg(tps_pkg::RTI, 8'h00, 1);
    leg(tps_pkg::SHF_DR, 8'h01, 3);
    leg(tps_pkg::RTI, 8'h03, 3);
    leg(tps_pkg::PAU_DR, 8'h05, 4);
    leg(tps_pkg::TLR, 8'h1F, 5);
    leg(tps_pkg::PAU_IR, 8'h16, 6);
    leg(tps_pkg::PAU_IR, 8'h2F, 7);
    leg(tps_pkg::SHF_IR, 8'h01, 2);
    do_reset();
    leg(tps_pkg::RTI, 8'h00, 1);
    leg(tps_pkg::SHF_IR, 8'h03, 4);
    refuse(tps_pkg::RTI, 8'h0B);
    do_reset();
    leg(tps_pkg::SHF_IR, 8'h06, 5);
    do_reset();
    leg(tps_pkg::PAU_DR, 8'h0A, 5);
    leg(tps_pkg::SHF_IR, 8'h0F, 6);
  endtask : t_shift

  initial begin
    do_reset();
    t_idle();
    t_pause_dr();
    t_pause_ir();
    t_shift();
    report_and_stop();
  end
endmodule : tb_tps_sequencer
